// ===== design/dtg_framer.sv
// Diagnosis telegram framer with AXI4-Lite register slave.
// Assumes fault causes and command pulses come from logic on aclk.
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module dtg_framer #(
  parameter logic [7:0] ID_HI = 8'h12,  // Arbitrary type code
  parameter logic [7:0] ID_LO = 8'h34   // Arbitrary type code
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [dtg_pkg::DTG_NFT-1:0] fault_cause,
  input  wire logic                        trip_reset,
  input  wire logic                        restart_cmd,
  input  wire logic                        freeze_cmd,
  input  wire logic                        sync_cmd,
  input  wire logic                        diag_req,
  output logic [7:0]                       tg_byte,
  output logic                             tg_valid,
  output logic                             tg_last,
  output logic [5:0]                       diag_len,
  output logic                             run_inhibit
);

  dtg_pkg::dtg_regs_t r_reg;
  dtg_pkg::dtg_regs_t r_next;

  logic                        static_flt;
  logic [7:0]                  st2;
  logic [7:0]                  st3;
  logic [5:0]                  cur_len;
  logic [DTG_NFT_W-1:0]        dummy_unused;
  localparam int DTG_NFT_W = 1;

  // ==========================================================
  // Status bytes
  always_comb
  begin
    static_flt = 1'b0;
    for (int i = 0; i < dtg_pkg::DTG_NFT; i++)
    begin
      if (dtg_pkg::DTG_FT_CLR[i] != dtg_pkg::DTG_CLR_LIVE)
        static_flt = static_flt | r_reg.flags[i];
    end
  end

  assign dummy_unused = 1'b0;
  assign st2 = {r_reg.ctrl[dtg_pkg::DTG_CTRL_DEACT],
                1'b0,
                r_reg.syn_vis,
                r_reg.frz_vis,
                r_reg.ctrl[dtg_pkg::DTG_CTRL_WDOG],
                r_reg.ctrl[dtg_pkg::DTG_CTRL_ADDR_OK],
                static_flt,
                r_reg.ctrl[dtg_pkg::DTG_CTRL_REPARAM]
                  | r_reg.flags[7]};
  assign st3 = {r_reg.ovf, 7'h00};
  assign cur_len = 6'(dtg_pkg::DTG_FIXED_LEN)
                   + {1'b0, r_reg.nent, 1'b0};
  assign run_inhibit = static_flt;

  // ==========================================================
  // Telegram byte selection
  function automatic logic [7:0] byte_at(input logic [5:0] k);
    logic [5:0] e;
    e = k - 6'(dtg_pkg::DTG_FIXED_LEN);
    case (k)
      6'h00: byte_at = r_reg.stat1;
      6'h01: byte_at = st2;
      6'h02: byte_at = st3;
      6'h03: byte_at = r_reg.maddr;
      6'h04: byte_at = ID_HI;
      6'h05: byte_at = ID_LO;
      6'h06: byte_at = dtg_pkg::DTG_ID_HDR;
      6'h07: byte_at = {7'h00, |r_reg.flags};
      6'h08: byte_at = dtg_pkg::DTG_MOD_HDR;
      6'h09: byte_at = dtg_pkg::DTG_MOD_TYPE;
      6'h0a: byte_at = 8'h00;
      6'h0b: byte_at = 8'h00;
      6'h0c: byte_at = {6'h00, |r_reg.flags, 1'b0};
      default:
      begin
        if (e[0] == 1'b0)
          byte_at = dtg_pkg::DTG_CH_HDR;
        else
          byte_at = {dtg_pkg::DTG_CH_TYPE, r_reg.ent[e[4:1]]};
      end
    endcase
  endfunction

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [dtg_pkg::DTG_NFT-1:0] nf;
    logic [4:0]                  cnt;
    logic                        chg;
    logic                        wr_do;
    nf = '0;
    cnt = 5'h00;
    chg = 1'b0;
    wr_do = 1'b0;
    r_next = r_reg;

    // Fault flags; cause always sets, so a set wins over any clear
    for (int i = 0; i < dtg_pkg::DTG_NFT; i++)
    begin
      case (dtg_pkg::DTG_FT_CLR[i])
        dtg_pkg::DTG_CLR_LIVE:
          nf[i] = fault_cause[i];
        dtg_pkg::DTG_CLR_CAUSEACK:
          nf[i] = fault_cause[i] | (r_reg.flags[i] & ~trip_reset);
        dtg_pkg::DTG_CLR_ACK:
          nf[i] = fault_cause[i] | (r_reg.flags[i] & ~trip_reset);
        dtg_pkg::DTG_CLR_RESTART:
          nf[i] = fault_cause[i] | (r_reg.flags[i] & ~restart_cmd);
        default:
          nf[i] = fault_cause[i];
      endcase
    end
    r_next.flags = nf;

    // Rebuild entries from the lowest fault type up; slots past the count stay untouched
    if (nf != r_reg.flags)
    begin
      for (int i = 0; i < dtg_pkg::DTG_NFT; i++)
      begin
        if (nf[i])
        begin
          if (cnt < 5'(dtg_pkg::DTG_MAX_ENT))
            r_next.ent[cnt[3:0]] = dtg_pkg::DTG_FT_CODE[i];
          cnt = cnt + 5'h01;
        end
      end
      r_next.nent = (cnt > 5'(dtg_pkg::DTG_MAX_ENT))
                    ? dtg_pkg::DTG_MAX_ENT : cnt[3:0];
      r_next.ovf = cnt > 5'(dtg_pkg::DTG_MAX_ENT);
      chg = 1'b1;
    end

    // AXI4-Lite write channel
    s_axi_awready = ~r_reg.aw_ok & ~r_reg.bvalid;
    s_axi_wready  = ~r_reg.w_ok & ~r_reg.bvalid;
    if (s_axi_awvalid && s_axi_awready)
    begin
      r_next.aw_ok = 1'b1;
      r_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      r_next.w_ok = 1'b1;
      r_next.wbyte = s_axi_wdata[7:0];
      r_next.wlane0 = s_axi_wstrb[0];
    end
    if (r_reg.aw_ok && r_reg.w_ok)
    begin
      wr_do = 1'b1;
      r_next.aw_ok = 1'b0;
      r_next.w_ok = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = dtg_pkg::DTG_RESP_OK;
      case ({r_reg.awaddr[7:2], 2'b00})
        dtg_pkg::DTG_CTRL_OFS:
          if (r_reg.wlane0) r_next.ctrl = r_reg.wbyte[3:0];
        dtg_pkg::DTG_MADDR_OFS:
          if (r_reg.wlane0) r_next.maddr = r_reg.wbyte;
        dtg_pkg::DTG_STAT1_OFS:
          if (r_reg.wlane0) r_next.stat1 = r_reg.wbyte;
        dtg_pkg::DTG_STATUS_OFS: wr_do = 1'b0;
        default:
        begin
          wr_do = 1'b0;
          r_next.bresp = dtg_pkg::DTG_RESP_ERR;
        end
      endcase
    end
    if (r_reg.bvalid && s_axi_bready)
      r_next.bvalid = 1'b0;

    // AXI4-Lite read channel
    s_axi_arready = ~r_reg.rvalid;
    if (s_axi_arvalid && s_axi_arready)
    begin
      r_next.rvalid = 1'b1;
      r_next.rresp = dtg_pkg::DTG_RESP_OK;
      case ({s_axi_araddr[7:2], 2'b00})
        dtg_pkg::DTG_CTRL_OFS:   r_next.rdata = {28'h0, r_reg.ctrl};
        dtg_pkg::DTG_MADDR_OFS:  r_next.rdata = {24'h0, r_reg.maddr};
        dtg_pkg::DTG_STAT1_OFS:  r_next.rdata = {24'h0, r_reg.stat1};
        dtg_pkg::DTG_STATUS_OFS:
          r_next.rdata = {r_reg.ovf, 9'h0, cur_len, 5'h0, r_reg.flags};
        default:
        begin
          r_next.rdata = 32'h0;
          r_next.rresp = dtg_pkg::DTG_RESP_ERR;
        end
      endcase
    end
    else if (r_reg.rvalid && s_axi_rready)
      r_next.rvalid = 1'b0;

    // Freeze and sync become visible only with a fault flag change or a write to the ctrl, maddr or stat1 register, whatever its value or strobe
    chg = chg | wr_do;
    if (chg)
    begin
      r_next.frz_vis = r_reg.frz_pend | freeze_cmd;
      r_next.syn_vis = r_reg.syn_pend | sync_cmd;
      r_next.frz_pend = 1'b0;
      r_next.syn_pend = 1'b0;
    end
    else
    begin
      r_next.frz_pend = r_reg.frz_pend | freeze_cmd;
      r_next.syn_pend = r_reg.syn_pend | sync_cmd;
    end

    // Telegram streaming
    r_next.tg_valid = 1'b0;
    r_next.tg_last = 1'b0;
    case (r_reg.st)
      dtg_pkg::DTG_IDLE:
        if (diag_req)
        begin
          r_next.st = dtg_pkg::DTG_SEND;
          r_next.idx = 6'h00;
          r_next.len = cur_len;
        end
      dtg_pkg::DTG_SEND:
      begin
        r_next.tg_valid = 1'b1;
        r_next.tg_byte = byte_at(r_reg.idx);
        r_next.tg_last = r_reg.idx == r_reg.len - 6'h01;
        r_next.idx = r_reg.idx + 6'h01;
        if (r_reg.idx == r_reg.len - 6'h01)
          r_next.st = dtg_pkg::DTG_IDLE;
      end
      default: r_next.st = dtg_pkg::DTG_IDLE;
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r_reg <= '0;
      r_reg.st <= dtg_pkg::DTG_IDLE;
      r_reg.ctrl <= dtg_pkg::DTG_CTRL_RST;
      r_reg.maddr <= dtg_pkg::DTG_MADDR_RST;
      r_reg.stat1 <= dtg_pkg::DTG_STAT1_RST;
    end
    else
      r_reg <= r_next;
  end

  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp  = r_reg.bresp;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rdata  = r_reg.rdata;
  assign s_axi_rresp  = r_reg.rresp;
  assign tg_byte      = r_reg.tg_byte;
  assign tg_valid     = r_reg.tg_valid;
  assign tg_last      = r_reg.tg_last;
  assign diag_len     = cur_len;

  // ==========================================================
  // Assertions
  sequence s_start;
    r_reg.st == dtg_pkg::DTG_IDLE && diag_req;
  endsequence
  sequence s_head;
    tg_valid && tg_byte == r_reg.stat1 ##1 tg_valid && !tg_byte[6]
      ##1 tg_valid && tg_byte[6:0] == 7'h00;
  endsequence

  property p_head;
    @(posedge aclk) disable iff (!aresetn)
    s_start |=> ##1 s_head;
  endproperty
  a_head: assert property (p_head) else $error("Bad status bytes");

  property p_len;
    @(posedge aclk) disable iff (!aresetn)
    cur_len >= 6'd13 && cur_len <= 6'd31;
  endproperty
  a_len: assert property (p_len) else $error("Length out of range");

  property p_ovf;
    @(posedge aclk) disable iff (!aresetn)
    r_reg.ovf |-> r_reg.nent == 4'h9 && st3 == 8'h80;
  endproperty
  a_ovf: assert property (p_ovf) else $error("Overflow mismatch");

  property p_short;
    @(posedge aclk) disable iff (!aresetn)
    r_reg.flags[0] && !trip_reset |=> r_reg.flags[0];
  endproperty
  a_short: assert property (p_short) else $error("Short cleared early");

  property p_overload;
    @(posedge aclk) disable iff (!aresetn)
    ##1 r_reg.flags[1] == $past(fault_cause[1]);
  endproperty
  a_overload: assert property (p_overload) else $error("Overload lag");

  property p_internal;
    @(posedge aclk) disable iff (!aresetn)
    r_reg.flags[6] && !restart_cmd |=> r_reg.flags[6];
  endproperty
  a_internal: assert property (p_internal) else $error("Fault lost");

  property p_param;
    @(posedge aclk) disable iff (!aresetn)
    r_reg.flags[7] && trip_reset && !fault_cause[7] |=> !r_reg.flags[7];
  endproperty
  a_param: assert property (p_param) else $error("Param not cleared");

  property p_missing;
    @(posedge aclk) disable iff (!aresetn)
    !fault_cause[8] |=> !r_reg.flags[8];
  endproperty
  a_missing: assert property (p_missing) else $error("Supply stuck");

  property p_inhibit;
    @(posedge aclk) disable iff (!aresetn)
    fault_cause[10] |=> run_inhibit && st2[1];
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("No inhibit");

endmodule
`default_nettype wire

// ===== design/dtg_pkg.sv
// Constants, types and register map of the diagnosis telegram framer.
// Assumes one 200 MHz clock and an AXI4-Lite master on the same clock.
package dtg_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] DTG_CTRL_OFS   = 8'h00;
  localparam logic [7:0] DTG_MADDR_OFS  = 8'h04;
  localparam logic [7:0] DTG_STAT1_OFS  = 8'h08;
  localparam logic [7:0] DTG_STATUS_OFS = 8'h0c;
  localparam int DTG_CTRL_REPARAM = 0;
  localparam int DTG_CTRL_ADDR_OK = 1;
  localparam int DTG_CTRL_WDOG    = 2;
  localparam int DTG_CTRL_DEACT   = 3;
  localparam logic [3:0] DTG_CTRL_RST  = 4'h0;
  localparam logic [7:0] DTG_MADDR_RST = 8'hff;
  localparam logic [7:0] DTG_STAT1_RST = 8'h00;
  localparam logic [1:0] DTG_RESP_OK   = 2'h0;
  localparam logic [1:0] DTG_RESP_ERR  = 2'h2;

  // ==========================================================
  // Telegram layout
  localparam logic [4:0] DTG_FIXED_LEN = 5'h0d;
  localparam logic [3:0] DTG_MAX_ENT   = 4'h9;
  localparam logic [7:0] DTG_ID_HDR    = 8'h42;
  localparam logic [7:0] DTG_MOD_HDR   = 8'h05;
  localparam logic [7:0] DTG_MOD_TYPE  = 8'h82;
  localparam logic [7:0] DTG_CH_HDR    = 8'hc0;
  localparam logic [2:0] DTG_CH_TYPE   = 3'h1;

  // ==========================================================
  // Fault types and clearing classes
  localparam int DTG_NFT = 11;
  localparam logic [1:0] DTG_CLR_LIVE    = 2'h0;
  localparam logic [1:0] DTG_CLR_CAUSEACK = 2'h1;
  localparam logic [1:0] DTG_CLR_ACK     = 2'h2;
  localparam logic [1:0] DTG_CLR_RESTART = 2'h3;
  localparam logic [DTG_NFT-1:0][4:0] DTG_FT_CODE = {
    5'h1a, 5'h18, 5'h11, 5'h10, 5'h09, 5'h08,
    5'h07, 5'h06, 5'h05, 5'h04, 5'h01};
  localparam logic [DTG_NFT-1:0][1:0] DTG_FT_CLR = {
    DTG_CLR_ACK, DTG_CLR_ACK, DTG_CLR_LIVE, DTG_CLR_ACK,
    DTG_CLR_RESTART, DTG_CLR_LIVE, DTG_CLR_LIVE, DTG_CLR_LIVE,
    DTG_CLR_CAUSEACK, DTG_CLR_LIVE, DTG_CLR_CAUSEACK};

  typedef enum logic [1:0] {
    DTG_IDLE = 2'b01,
    DTG_SEND = 2'b10
  } dtg_state_t;

  typedef struct packed {
    dtg_state_t            st;
    logic [5:0]            idx;
    logic [5:0]            len;
    logic [7:0]            tg_byte;
    logic                  tg_valid;
    logic                  tg_last;
    logic [DTG_NFT-1:0]    flags;
    logic [8:0][4:0]       ent;
    logic [3:0]            nent;
    logic                  ovf;
    logic                  frz_pend;
    logic                  syn_pend;
    logic                  frz_vis;
    logic                  syn_vis;
    logic [3:0]            ctrl;
    logic [7:0]            maddr;
    logic [7:0]            stat1;
    logic                  aw_ok;
    logic [7:0]            awaddr;
    logic                  w_ok;
    logic [7:0]            wbyte;
    logic                  wlane0;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } dtg_regs_t;

endpackage

// ===== testbench/dtg_master_model.sv
// Bus master model: requests diagnosis telegrams and captures them.
// Assumes the framer's telegram stream runs on aclk with no back-pressure.
`timescale 1ns/1ps
`default_nettype none
module dtg_master_model (
  input  wire logic       aclk,
  input  wire logic [7:0] tg_byte,
  input  wire logic       tg_valid,
  input  wire logic       tg_last,
  output var  logic       diag_req
);
  // ==========================================================
  // Capture buffer
  logic [7:0] rx [0:63];
  int         rx_len;
  int         stray;

  initial diag_req = 1'h0;

  // ==========================================================
  // Fetch one telegram; a second request is made mid-frame and must
  // be ignored; only bytes up to the reported last byte are kept
  task automatic read_diag();
    int n;
    n = 0;
    rx_len = 0;
    stray = 0;
    diag_req <= 1'h1;
    @(posedge aclk);
    while (n < 80)
    begin
      @(posedge aclk);
      n++;
      diag_req <= (rx_len == 3);
      if (tg_valid === 1'h1)
      begin
        rx[rx_len] = tg_byte;
        rx_len++;
        if (tg_last === 1'h1)
          break;
      end
    end
    repeat (6)
    begin
      @(posedge aclk);
      if (tg_valid !== 1'h0)
        stray++;
    end
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the diagnosis telegram framer.
// Assumes the master model sits on the telegram stream.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================================
  // Signals
  logic        aclk          = 1'h0;
  logic        aresetn       = 1'h0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic [3:0]  s_axi_wstrb   = 4'hf;
  logic        s_axi_wvalid  = 1'h0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready  = 1'h1;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready  = 1'h1;
  logic [10:0] fault_cause   = 11'h0;
  logic [3:0]  cmd           = 4'h0;
  logic        diag_req;
  logic [7:0]  tg_byte;
  logic        tg_valid;
  logic        tg_last;
  logic [5:0]  diag_len;
  logic        run_inhibit;
  logic [3:0]  ctrl_m        = 4'h0;
  logic [7:0]  maddr_m       = 8'hff;
  logic [7:0]  stat1_m       = 8'h00;
  int          failures      = 0;
  int          tests_run     = 0;
  int          cycles        = 0;
  localparam logic [7:0]  ID_HI = 8'h5a;  // Arbitrary type code
  localparam logic [7:0]  ID_LO = 8'hc3;  // Arbitrary type code
  localparam logic [10:0] LATCH = 11'h6c5;
  localparam logic [4:0]  CODE [0:10] = '{5'h01, 5'h04, 5'h05, 5'h06,
    5'h07, 5'h08, 5'h09, 5'h10, 5'h11, 5'h18, 5'h1a};
  localparam int          CLS [0:10] = '{1, 0, 1, 0, 0, 0, 3, 2, 0, 2, 2};
  localparam logic [7:0]  RA [0:4] = '{dtg_pkg::DTG_CTRL_OFS,
    dtg_pkg::DTG_MADDR_OFS, dtg_pkg::DTG_STAT1_OFS,
    dtg_pkg::DTG_STATUS_OFS, 8'h10};
  localparam logic [31:0] RD [0:4] = '{32'h0, 32'hff, 32'h0, 32'h000d0000,
    32'h0};

  always #2.5 aclk = ~aclk;

  dtg_framer #(.ID_HI(ID_HI), .ID_LO(ID_LO)) i_dtg_framer (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .fault_cause, .trip_reset(cmd[0]),
    .restart_cmd(cmd[1]), .freeze_cmd(cmd[2]), .sync_cmd(cmd[3]),
    .diag_req, .tg_byte, .tg_valid, .tg_last, .diag_len, .run_inhibit);

  dtg_master_model i_dtg_master_model (
    .aclk, .tg_byte, .tg_valid, .tg_last, .diag_req);

  // ==========================================================
  // Tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic pulse(input int k);
    cmd[k] <= 1'h1;
    @(posedge aclk);
    cmd[k] <= 1'h0;
    tick(3);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic flag_chk(input int k, input logic e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(dtg_pkg::DTG_STATUS_OFS, d, r);
    chk({run_inhibit, d[10:0]}, {e & LATCH[k], 11'(e) << k});
  endtask

  task automatic tg_check(input logic [10:0] fl, input logic [1:0] fs);
    logic [7:0] e [0:31];
    int         n;
    int         j;
    n = 0;
    e[0] = stat1_m;
    e[1] = {ctrl_m[3], 1'h0, fs, ctrl_m[2:1], |(fl & LATCH),
            ctrl_m[0] | fl[7]};
    e[2] = {($countones(fl) > 9), 7'h00};
    e[3] = maddr_m;
    e[4] = ID_HI;
    e[5] = ID_LO;
    e[6] = dtg_pkg::DTG_ID_HDR;
    e[8] = dtg_pkg::DTG_MOD_HDR;
    e[9] = dtg_pkg::DTG_MOD_TYPE;
    e[10] = 8'h00;
    e[11] = 8'h00;
    for (j = 0; j < 11; j++)
      if (fl[j] && n < 9)
      begin
        e[13 + 2 * n] = 8'hc0;
        e[14 + 2 * n] = {3'h1, CODE[j]};
        n++;
      end
    chk(i_dtg_master_model.rx_len, 13 + 2 * n);
    chk(i_dtg_master_model.stray, 0);
    for (j = 0; j < 13 + 2 * n; j++)
      if (j != 7 && j != 12)
        chk(i_dtg_master_model.rx[j], e[j]);
  endtask

  // ==========================================================
  // Timeout
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      failures++;
      summarize();
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    int          i;
    int          k;
    tick(16);
    aresetn <= 1'h1;
    tick(1);
    for (i = 0; i < 5; i++)
    begin
      axi_rd(RA[i], d, r);
      chk({r, d}, {(i == 4) ? 2'h2 : 2'h0, RD[i]});
    end
    axi_wr(8'h10, 32'h1, r);
    chk(r, 2'h2);
    axi_wr(dtg_pkg::DTG_STATUS_OFS, 32'hffffffff, r);
    chk(r, 2'h0);
    i_dtg_master_model.read_diag();
    tg_check(11'h0, 2'h0);
    maddr_m = 8'h2e;
    stat1_m = 8'h91;
    axi_wr(dtg_pkg::DTG_MADDR_OFS, 32'habcdef2e, r);
    axi_wr(dtg_pkg::DTG_STAT1_OFS, {24'h0, stat1_m}, r);
    axi_rd(dtg_pkg::DTG_MADDR_OFS, d, r);
    chk(d, {24'h0, maddr_m});
    for (i = 0; i < 2; i++)
    begin
      ctrl_m = (i == 0) ? 4'h5 : 4'ha;
      axi_wr(dtg_pkg::DTG_CTRL_OFS, {28'h0, ctrl_m}, r);
      axi_rd(dtg_pkg::DTG_CTRL_OFS, d, r);
      chk(d, {28'h0, ctrl_m});
      i_dtg_master_model.read_diag();
      tg_check(11'h0, 2'h0);
    end
    pulse(2);
    i_dtg_master_model.read_diag();
    tg_check(11'h0, 2'h0);
    fault_cause <= 11'h080;
    tick(3);
    i_dtg_master_model.read_diag();
    tg_check(11'h080, 2'h1);
    chk(run_inhibit, 1'h1);
    pulse(3);
    fault_cause <= 11'h0;
    tick(3);
    pulse(0);
    i_dtg_master_model.read_diag();
    tg_check(11'h0, 2'h2);
    for (k = 0; k < 11; k++)
    begin
      fault_cause[k] <= 1'h1;
      tick(2);
      pulse(0);
      pulse(1);
      flag_chk(k, 1'h1);
      fault_cause[k] <= 1'h0;
      tick(3);
      flag_chk(k, CLS[k] != 0);
      pulse(0);
      flag_chk(k, CLS[k] == 3);
      pulse(1);
      flag_chk(k, 1'h0);
    end
    fault_cause <= 11'h7ff;
    tick(3);
    axi_rd(dtg_pkg::DTG_STATUS_OFS, d, r);
    chk(d, 32'h801f07ff);
    chk(diag_len, 6'h1f);
    i_dtg_master_model.read_diag();
    tg_check(11'h7ff, 2'h0);
    fault_cause <= 11'h0;
    tick(3);
    pulse(0);
    pulse(1);
    chk(diag_len, 6'h0d);
    i_dtg_master_model.read_diag();
    tg_check(11'h0, 2'h0);
    summarize();
  end
endmodule
`default_nettype wire
